// [hw/dsr_speed_run_select.sv]
/*
 * Speed reference and run command selector of the drive: picks the
 * frequency reference, decodes run/stop/direction, applies the stop key
 * lock, reverse inhibit, clamps and the stop ramp.
 * Assumes all inputs but the three terminal inputs, which are synchronized here, are synchronous to clk_sys, analog inputs arrive
 * as converter codes, and the serial link is decoded elsewhere.
 */
`timescale 1ns/1ns

module dsr_speed_run_select
    import dsr_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int TENTH_CYCLES = TENTH_CYC,
    parameter int UPDN_TICK_CYCLES = UPDN_TICK_CYC,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [FW-1:0] digitalFrequencySetpoint,
    input wire logic setpointWrite,
    input wire logic keyUp,
    input wire logic keyDown,
    input wire logic [2:0] frequencySourceSelect,
    input wire logic [1:0] runCommandSource,
    input wire logic stopKeyLock,
    input wire logic enterKey,
    input wire logic reversePermit,
    input wire logic [FW-1:0] frequencyCeiling,
    input wire logic [FW-1:0] frequencyFloor,
    input wire logic [DEC_W-1:0] decelTime,
    input wire logic [ADC_W-1:0] voltageReferenceInput,
    input wire logic [ADC_W-1:0] currentReferenceInput,
    input wire logic [ADC_W-1:0] panelDialInput,
    input wire logic multiInputOne,
    input wire logic multiInputTwo,
    input wire logic multiInputThree,
    input wire logic [FN_W-1:0] inputOneFunctionSelect,
    input wire logic [FN_W-1:0] inputTwoFunctionSelect,
    input wire logic [FN_W-1:0] inputThreeFunctionSelect,
    input wire logic panelRunKey,
    input wire logic panelDirKey,
    input wire logic panelStopKey,
    input wire logic commRun,
    input wire logic commReverse,
    input wire logic [FW-1:0] commFrequency,
    output wire logic [FW-1:0] outFrequency,
    output wire logic [FW-1:0] referenceFrequency,
    output wire logic runCommand,
    output wire logic reverseRunning,
    output wire logic motorActive,
    output wire logic stopKeyEnabled
);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
    localparam logic [UPDN_W-1:0] UPDN_LAST = UPDN_W'(UPDN_TICK_CYCLES - 1);
    localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

    typedef struct packed {
        dsr_run_t state;
        logic runReq;
        logic dirReq;
        logic outDir;
        logic [FW-1:0] stored;
        logic [FW-1:0] work;
        logic [FW-1:0] updn;
        logic [FW-1:0] refq;
        logic [FW-1:0] outFreq;
        logic [ACC_W-1:0] acc;
        logic [HOLD_W-1:0] holdCnt;
        logic stopKeyEn;
        logic termBlock;
        logic [UPDN_W-1:0] updnCnt;
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] clean;
        logic [NIN-1:0][DB_W-1:0] dbCnt;
        logic fwdLast;
        logic revLast;
        logic active;
    } dsr_state_t;

    dsr_state_t s_q;
    dsr_state_t s_d;

    logic [NIN-1:0] rawIn;
    logic [NIN-1:0][FN_W-1:0] fnSel;
    logic [NIN-1:0] isFwd, isRev, isStop, isUp, isDown, hasStop;
    logic fwdIn, revIn, stopIn, upIn, downIn, threeWire;
    logic [FW-1:0] ceilEff;

    assign rawIn = {multiInputThree, multiInputTwo, multiInputOne};
    assign fnSel = {inputThreeFunctionSelect, inputTwoFunctionSelect,
                    inputOneFunctionSelect};

    // per-terminal function decode on the debounced levels
    for (genvar i = 0; i < NIN; i++)
    begin : g_decode
        assign isFwd[i] = s_q.clean[i] && fnSel[i] == FN_FWD;
        assign isRev[i] = s_q.clean[i] && fnSel[i] == FN_REV;
        assign isStop[i] = s_q.clean[i] && fnSel[i] == FN_STOP;
        assign hasStop[i] = fnSel[i] == FN_STOP;
        assign isUp[i] = s_q.clean[i] && fnSel[i] == FN_UP;
        assign isDown[i] = s_q.clean[i] && fnSel[i] == FN_DOWN;
    end

    // a terminal carrying the stop function switches to three-wire mode
    assign fwdIn = |isFwd;
    assign revIn = |isRev;
    assign stopIn = |isStop;
    assign upIn = |isUp;
    assign downIn = |isDown;
    assign threeWire = |hasStop;
    assign ceilEff = (frequencyCeiling > FREQ_ABS_MAX) ? FREQ_ABS_MAX
                                                       : frequencyCeiling;

    // linear scale, code+msb lets full scale land exactly on the ceiling
    function automatic logic [FW-1:0] scaleRef(
        input logic [ADC_W-1:0] code,
        input logic [FW-1:0] ceil
    );
        logic [ADC_W:0] c;
        logic [ADC_W+FW:0] p;
        c = {1'b0, code} + (ADC_W+1)'(code[ADC_W-1]);
        p = (ADC_W+FW+1)'(c) * (ADC_W+FW+1)'(ceil);
        return p[ADC_W+FW-1:ADC_W];
    endfunction : scaleRef

    // next-state logic for the whole block
    always_comb
    begin
        logic [FW-1:0] r;
        logic [FW-1:0] target;
        logic [DEC_W-1:0] decEff;
        logic [ACC_W-1:0] limit;
        logic [ACC_W-1:0] accSum;
        logic fwdFall;
        logic revFall;
        r = '0;
        target = '0;
        decEff = (decelTime == '0) ? DEC_MIN : decelTime;
        limit = ACC_W'(decEff) * ACC_W'(TENTH_CYCLES);
        accSum = s_q.acc + ACC_W'(ceilEff);
        fwdFall = s_q.fwdLast && !fwdIn;
        revFall = s_q.revLast && !revIn;
        s_d = s_q;

        // two-stage sync, then a level must hold to pass
        s_d.sync1 = rawIn;
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < NIN; i++)
        begin
            if (s_q.sync2[i] == s_q.clean[i])
                s_d.dbCnt[i] = '0;
            else if (s_q.dbCnt[i] == DB_LAST)
            begin
                s_d.clean[i] = s_q.sync2[i];
                s_d.dbCnt[i] = '0;
            end
            else
                s_d.dbCnt[i] = DB_W'(s_q.dbCnt[i] + 8'h01);
        end
        s_d.fwdLast = fwdIn;
        s_d.revLast = revIn;

        // stop key lock takes the new setting only after a long hold
        if (!enterKey)
            s_d.holdCnt = '0;
        else if (s_q.holdCnt == HOLD_LAST)
            s_d.stopKeyEn = stopKeyLock;
        else
            s_d.holdCnt = HOLD_W'(s_q.holdCnt + 28'h0000001);

        // keypad keys only move the working copy
        if (keyUp && !keyDown && s_q.work < ceilEff)
            s_d.work = FW'(s_q.work + FREQ_STEP);
        else if (keyDown && !keyUp && s_q.work > frequencyFloor)
            s_d.work = FW'(s_q.work - FREQ_STEP);
        if (setpointWrite)
        begin
            // nonvolatile save of the stored copy is done outside
            s_d.stored = (digitalFrequencySetpoint > ceilEff) ? ceilEff
                         : digitalFrequencySetpoint;
            s_d.work = s_d.stored;
        end

        // up/down terminals, one step per tick
        if (s_q.updnCnt == UPDN_LAST)
        begin
            s_d.updnCnt = '0;
            if (upIn && !downIn && s_q.updn < ceilEff)
                s_d.updn = FW'(s_q.updn + FREQ_STEP);
            else if (downIn && !upIn && s_q.updn > frequencyFloor)
                s_d.updn = FW'(s_q.updn - FREQ_STEP);
        end
        else
            s_d.updnCnt = UPDN_W'(s_q.updnCnt + 24'h000001);

        // frequency reference selection
        case (frequencySourceSelect)
            FSRC_DIGITAL: r = s_q.work;
            FSRC_VOLT: r = scaleRef(voltageReferenceInput, ceilEff);
            FSRC_CURR: r = scaleRef(currentReferenceInput, ceilEff);
            FSRC_DIAL: r = scaleRef(panelDialInput, ceilEff);
            FSRC_UPDN: r = s_q.updn;
            FSRC_COMM: r = commFrequency;
            default: r = frequencyFloor;
        endcase
        if (r > ceilEff)
            r = ceilEff;
        if (r < frequencyFloor)
            r = frequencyFloor;
        s_d.refq = r;

        // a halted source must drop its request before it may restart
        if (s_q.termBlock &&
            !((runCommandSource == RSRC_TERM) ? (fwdIn || revIn) : commRun))
            s_d.termBlock = 1'b0;

        // run command decode
        case (runCommandSource)
            RSRC_PANEL:
            begin
                if (panelDirKey)
                    s_d.dirReq = !s_q.dirReq;
                if (panelRunKey)
                    s_d.runReq = 1'b1;
            end
            RSRC_TERM:
            begin
                if (s_q.termBlock)
                    s_d.runReq = 1'b0;
                else if (threeWire)
                begin
                    // the latch only changes direction on a fresh pulse
                    if (!stopIn)
                        s_d.runReq = 1'b0;
                    else if (fwdFall)
                    begin
                        s_d.runReq = 1'b1;
                        s_d.dirReq = 1'b0;
                    end
                    else if (revFall && reversePermit)
                    begin
                        s_d.runReq = 1'b1;
                        s_d.dirReq = 1'b1;
                    end
                end
                else if (fwdIn && !revIn)
                begin
                    s_d.runReq = 1'b1;
                    s_d.dirReq = 1'b0;
                end
                else if (revIn && !fwdIn)
                begin
                    if (reversePermit)
                    begin
                        s_d.runReq = 1'b1;
                        s_d.dirReq = 1'b1;
                    end
                end
                else if (!fwdIn && !revIn)
                    s_d.runReq = 1'b0;
            end
            RSRC_COMM:
            begin
                s_d.runReq = !s_q.termBlock && commRun &&
                             (reversePermit || !commReverse);
                s_d.dirReq = commReverse;
            end
            default: s_d.runReq = 1'b0;
        endcase

        // an enabled stop key wins over any source
        if (panelStopKey && s_q.stopKeyEn)
        begin
            s_d.runReq = 1'b0;
            if (runCommandSource != RSRC_PANEL)
                s_d.termBlock = 1'b1;
        end
        if (!reversePermit)
            s_d.dirReq = 1'b0;

        // every fresh start reloads the working copy from the stored setpoint
        if (s_d.runReq && !s_q.runReq)
            s_d.work = s_q.stored;

        // run sequencing; reversal passes through zero first
        unique case (s_q.state)
            RS_IDLE:
                if (s_q.runReq)
                begin
                    s_d.state = RS_RUN;
                    s_d.outDir = s_q.dirReq;
                end
            RS_RUN:
                if (!s_q.runReq)
                    s_d.state = RS_DECEL;
                else if (s_q.dirReq != s_q.outDir && s_q.outFreq == '0)
                    s_d.outDir = s_q.dirReq;
            RS_DECEL:
                if (s_q.runReq)
                    s_d.state = RS_RUN;
                else if (s_q.outFreq == '0)
                    s_d.state = RS_IDLE;
        endcase
        // registered copy so the activity output comes from a flop
        s_d.active = s_d.state != RS_IDLE;
        if (s_q.state == RS_RUN && s_q.dirReq == s_q.outDir)
            target = s_q.refq;

        // rate accumulator: ceiling steps per deceleration time
        if (s_q.outFreq == target)
            s_d.acc = '0;
        else if (accSum >= limit)
        begin
            s_d.acc = accSum - limit;
            s_d.outFreq = (s_q.outFreq < target)
                          ? FW'(s_q.outFreq + FREQ_STEP)
                          : FW'(s_q.outFreq - FREQ_STEP);
        end
        else
            s_d.acc = accSum;
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.state <= RS_IDLE;
            s_q.stored <= SETPOINT_RST;
            s_q.work <= SETPOINT_RST;
            s_q.updn <= FLOOR_RST;
            s_q.stopKeyEn <= STOPKEY_RST;
        end
        else
            s_q <= s_d;
    end

    assign outFrequency = s_q.outFreq;
    assign referenceFrequency = s_q.refq;
    assign runCommand = s_q.runReq;
    assign reverseRunning = s_q.outDir;
    assign motorActive = s_q.active;
    assign stopKeyEnabled = s_q.stopKeyEn;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_fwd_pulse;
        (runCommandSource == RSRC_TERM && threeWire && fwdIn)
        ##1 (runCommandSource == RSRC_TERM && threeWire && stopIn &&
             !fwdIn && !s_q.termBlock && !panelStopKey);
    endsequence
    sequence s_panel_halt;
        runCommandSource == RSRC_TERM && panelStopKey && s_q.stopKeyEn;
    endsequence

    property p_digital_src;
        frequencySourceSelect == FSRC_DIGITAL && s_q.work <= ceilEff &&
        s_q.work >= frequencyFloor |=> s_q.refq == $past(s_q.work);
    endproperty
    a_digital_src: assert property (p_digital_src)
        else $error("digital source not followed");

    property p_store;
        setpointWrite && digitalFrequencySetpoint <= ceilEff
        |=> s_q.stored == $past(digitalFrequencySetpoint);
    endproperty
    a_store: assert property (p_store)
        else $error("setpoint write not stored");

    property p_start_reload;
        $rose(s_q.runReq) |-> s_q.work == $past(s_q.stored);
    endproperty
    a_start_reload: assert property (p_start_reload)
        else $error("start did not reload stored setpoint");

    property p_updn_hold;
        upIn && downIn |=> s_q.updn == $past(s_q.updn);
    endproperty
    a_updn_hold: assert property (p_updn_hold)
        else $error("up and down together changed frequency");

    property p_two_wire;
        runCommandSource == RSRC_TERM && !threeWire && !s_q.termBlock &&
        fwdIn && !revIn && !panelStopKey |=> s_q.runReq && !s_q.dirReq;
    endproperty
    a_two_wire: assert property (p_two_wire)
        else $error("forward input did not start forward");

    property p_three_latch;
        s_fwd_pulse |=> s_q.runReq && !s_q.dirReq;
    endproperty
    a_three_latch: assert property (p_three_latch)
        else $error("forward pulse not latched");

    property p_three_stop;
        runCommandSource == RSRC_TERM && threeWire && !stopIn
        |=> !s_q.runReq;
    endproperty
    a_three_stop: assert property (p_three_stop)
        else $error("stop input did not clear run");

    property p_lock_hold;
        enterKey && s_q.holdCnt == HOLD_LAST
        |=> s_q.stopKeyEn == $past(stopKeyLock);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("stop key lock not applied");

    property p_panel_halt;
        s_panel_halt |=> !s_q.runReq && s_q.termBlock;
    endproperty
    a_panel_halt: assert property (p_panel_halt)
        else $error("panel stop did not block terminals");

    property p_no_reverse;
        !reversePermit |=> !s_q.dirReq;
    endproperty
    a_no_reverse: assert property (p_no_reverse)
        else $error("reverse requested while prohibited");

    property p_clamp;
        frequencyFloor <= ceilEff |=> s_q.refq <= $past(ceilEff) &&
                                      s_q.refq >= $past(frequencyFloor);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("reference outside floor and ceiling");

    property p_decel;
        s_q.state == RS_DECEL && s_q.outFreq != '0 |=>
        s_q.outFreq == $past(s_q.outFreq) ||
        s_q.outFreq == FW'($past(s_q.outFreq) - FREQ_STEP);
    endproperty
    a_decel: assert property (p_decel)
        else $error("stop ramp not monotone single step");
endmodule : dsr_speed_run_select

// [hw/dsr_pkg.sv]
/*
 * Constants for the speed reference and run command selector: selector
 * codes, terminal function codes, frequency limits, reset values and
 * timing figures for a 125 MHz system clock.
 * Assumes frequencies are carried in 0.01 Hz units on 16-bit words.
 */
package dsr_pkg;
    // clock and word widths
    localparam int CLK_HZ = 125_000_000;
    localparam int FW = 16;
    localparam int ADC_W = 12;
    localparam int FN_W = 5;
    localparam int DEC_W = 14;
    localparam int NIN = 3;
    localparam int HOLD_W = 28;
    localparam int UPDN_W = 24;
    localparam int DB_W = 8;
    localparam int ACC_W = 40;

    // frequencies in 0.01 Hz steps
    localparam logic [FW-1:0] FREQ_ABS_MAX = 16'h9C40; // 400.00 Hz
    localparam logic [FW-1:0] CEIL_RST = 16'h1388; // 50.00 Hz
    localparam logic [FW-1:0] FLOOR_RST = 16'h0000;
    localparam logic [FW-1:0] SETPOINT_RST = 16'h0000;
    localparam logic [FW-1:0] FREQ_STEP = 16'h0001;
    localparam logic [DEC_W-1:0] DEC_MIN = 14'h0001; // 0.1 s

    // frequency source codes
    localparam logic [2:0] FSRC_DIGITAL = 3'h0;
    localparam logic [2:0] FSRC_VOLT = 3'h1;
    localparam logic [2:0] FSRC_CURR = 3'h2;
    localparam logic [2:0] FSRC_DIAL = 3'h3;
    localparam logic [2:0] FSRC_UPDN = 3'h4;
    localparam logic [2:0] FSRC_COMM = 3'h5;

    // run command source codes
    localparam logic [1:0] RSRC_PANEL = 2'h0;
    localparam logic [1:0] RSRC_TERM = 2'h1;
    localparam logic [1:0] RSRC_COMM = 2'h2;

    // terminal function codes
    localparam logic [FN_W-1:0] FN_FWD = 5'h06;
    localparam logic [FN_W-1:0] FN_REV = 5'h07;
    localparam logic [FN_W-1:0] FN_STOP = 5'h09;
    localparam logic [FN_W-1:0] FN_UP = 5'h0F;
    localparam logic [FN_W-1:0] FN_DOWN = 5'h10;

    localparam logic STOPKEY_RST = 1'b1;

    // timing figures and their cycle counts
    localparam int HOLD_MS = 2000;
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    localparam int TENTH_MS = 100;
    localparam int TENTH_CYC = TENTH_MS * (CLK_HZ / 1000);
    localparam int UPDN_TICK_MS = 10;
    localparam int UPDN_TICK_CYC = UPDN_TICK_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_CYC = 16;

    typedef enum logic [1:0] {RS_IDLE, RS_RUN, RS_DECEL} dsr_run_t;
endpackage : dsr_pkg

// [dv/dsr_switch_model.sv]
/*
 * Terminal switch bank facing the selector: three contacts that close
 * when commanded, with no bounce of their own.
 * Assumes the bench changes the commands off the rising clock edge.
 */
`timescale 1ns/1ns

module dsr_switch_model
(
    input wire logic clk_sys,
    input wire logic [2:0] swClosed,
    output logic multiInputOne,
    output logic multiInputTwo,
    output logic multiInputThree
);
    // contacts follow the command; an opposite-direction pulse is made
    // by the bench closing then opening one contact
    always_comb
    begin
        multiInputOne = swClosed[0];
        multiInputTwo = swClosed[1];
        multiInputThree = swClosed[2];
    end
endmodule : dsr_switch_model

// [dv/dsr_speed_run_select_tb.sv]
/*
 * Self-checking bench for the speed and run selector: setpoint, source
 * table, keypad, two-wire, three-wire, stop key lock and up/down.
 * Assumes shortened timing parameters and a 125 MHz clock.
 */
`timescale 1ns/1ns

module dsr_speed_run_select_tb
    import dsr_pkg::*;
;
    logic clk_sys = 0, rst = 1, setpointWrite = 0, keyUp = 0, keyDown = 0;
    logic stopKeyLock = 1, enterKey = 0, reversePermit = 1;
    logic panelRunKey = 0, panelDirKey = 0, panelStopKey = 0;
    logic commRun = 0, commReverse = 0, runCommand, reverseRunning;
    logic motorActive, stopKeyEnabled, mi1, mi2, mi3;
    logic [2:0] frequencySourceSelect = 0, swClosed = 0;
    logic [1:0] runCommandSource = 0;
    logic [FW-1:0] setp = 0, ceil = CEIL_RST, flr = 0, commF = 16'h0ABC;
    logic [FW-1:0] outFrequency, refF, base;
    logic [ADC_W-1:0] volt = 12'hFFF, curr = 12'h000, dial = 12'h800;
    logic [FN_W-1:0] fn1 = FN_FWD, fn2 = FN_REV, fn3 = 5'h00;
    logic [DEC_W-1:0] dec = DEC_MIN;
    logic [2:0] srcs [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [FW-1:0] exps [6] = '{16'h1388, 16'h0010, 16'h09C5, 16'h0ABC,
                                16'h0010, 16'h0010};
    int fails = 0, num_checks = 0, cyc = 0;

    always #4 clk_sys = ~clk_sys;

    dsr_switch_model u_dsr_switch_model (.clk_sys(clk_sys),
        .swClosed(swClosed), .multiInputOne(mi1), .multiInputTwo(mi2),
        .multiInputThree(mi3));

    // short counts keep the hold, ramp and tick figures within the run
    dsr_speed_run_select #(.HOLD_CYCLES(20), .TENTH_CYCLES(4),
        .UPDN_TICK_CYCLES(4), .DEBOUNCE_CYCLES(2)) u_dsr_speed_run_select (
        .clk_sys(clk_sys), .rst(rst), .digitalFrequencySetpoint(setp),
        .setpointWrite(setpointWrite), .keyUp(keyUp), .keyDown(keyDown),
        .frequencySourceSelect(frequencySourceSelect),
        .runCommandSource(runCommandSource), .stopKeyLock(stopKeyLock),
        .enterKey(enterKey), .reversePermit(reversePermit),
        .frequencyCeiling(ceil), .frequencyFloor(flr),
        .decelTime(dec), .voltageReferenceInput(volt),
        .currentReferenceInput(curr), .panelDialInput(dial),
        .multiInputOne(mi1), .multiInputTwo(mi2), .multiInputThree(mi3),
        .inputOneFunctionSelect(fn1), .inputTwoFunctionSelect(fn2),
        .inputThreeFunctionSelect(fn3), .panelRunKey(panelRunKey),
        .panelDirKey(panelDirKey), .panelStopKey(panelStopKey),
        .commRun(commRun), .commReverse(commReverse),
        .commFrequency(commF), .outFrequency(outFrequency),
        .referenceFrequency(refF), .runCommand(runCommand),
        .reverseRunning(reverseRunning), .motorActive(motorActive),
        .stopKeyEnabled(stopKeyEnabled));

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic chk(input string name, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask : chk

    // bounded wait on a run output; the caller compares afterwards
    task automatic waitBit(input int which, input logic exp, input int mx);
        for (int n = 0; n < mx; n++)
        begin
            tick(1);
            if ((which == 0 ? runCommand : reverseRunning) === exp)
                break;
        end
    endtask : waitBit

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // hang guard well above the length of the sequence
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        tick(2);
        rst = 0;
        tick(1);
        chk("rst ref", refF, 16'h0000);
        chk("rst key", {15'h0, stopKeyEnabled}, 16'h0001);
        setp = 16'h0100; setpointWrite = 1; tick(1); setpointWrite = 0;
        tick(3);
        chk("setpoint", refF, 16'h0100);
        flr = 16'h0200; tick(3);
        chk("floor", refF, 16'h0200);
        flr = 16'h0010;
        for (int i = 0; i < 6; i++)
        begin
            frequencySourceSelect = srcs[i]; tick(3);
            chk("source", refF, exps[i]);
        end
        frequencySourceSelect = FSRC_DIGITAL; flr = 0;
        keyUp = 1; tick(1); keyUp = 0; tick(3);
        chk("key up", refF, 16'h0101);
        panelRunKey = 1; panelDirKey = 1; tick(1);
        panelRunKey = 0; panelDirKey = 0; tick(3);
        chk("panel run", {15'h0, runCommand}, 16'h0001);
        chk("reload", refF, 16'h0100);
        chk("panel dir", {15'h0, reverseRunning}, 16'h0001);
        panelStopKey = 1; tick(1); panelStopKey = 0; tick(2);
        chk("panel stop", {15'h0, runCommand}, 16'h0000);
        setp = 16'hFFFF; setpointWrite = 1; tick(1); setpointWrite = 0;
        tick(3);
        chk("ceiling", refF, 16'h1388);
        // two-wire: a short glitch must not start the drive
        runCommandSource = RSRC_TERM;
        swClosed = 3'b001; tick(1); swClosed = 0; tick(12);
        chk("glitch", {15'h0, runCommand}, 16'h0000);
        swClosed = 3'b001; waitBit(0, 1, 20);
        chk("fwd run", {15'h0, runCommand}, 16'h0001);
        panelStopKey = 1; tick(1); panelStopKey = 0; tick(12);
        chk("blocked", {15'h0, runCommand}, 16'h0000);
        swClosed = 0; tick(12); swClosed = 3'b001; waitBit(0, 1, 20);
        chk("restart", {15'h0, runCommand}, 16'h0001);
        swClosed = 3'b011; tick(15);
        chk("both keep", {15'h0, runCommand}, 16'h0001);
        chk("both dir", {15'h0, reverseRunning}, 16'h0000);
        reversePermit = 0; swClosed = 3'b010; tick(200);
        chk("rev inhibit", {15'h0, reverseRunning}, 16'h0000);
        reversePermit = 1; waitBit(1, 1, 600);
        chk("rev run", {15'h0, reverseRunning}, 16'h0001);
        swClosed = 0; waitBit(0, 0, 20);
        chk("both off", {15'h0, runCommand}, 16'h0000);
        // stop key locked out after a held enter
        stopKeyLock = 0; enterKey = 1; tick(25); enterKey = 0; tick(1);
        chk("lock", {15'h0, stopKeyEnabled}, 16'h0000);
        swClosed = 3'b001; waitBit(0, 1, 20);
        panelStopKey = 1; tick(1); panelStopKey = 0; tick(4);
        chk("key ignored", {15'h0, runCommand}, 16'h0001);
        stopKeyLock = 1; enterKey = 1; tick(25); enterKey = 0;
        swClosed = 0; waitBit(0, 0, 20);
        // three-wire: pulse latches, stop contact opening clears
        fn3 = FN_STOP; swClosed = 3'b100; tick(10);
        swClosed = 3'b101; tick(10); swClosed = 3'b100; waitBit(0, 1, 20);
        chk("3w latch", {15'h0, runCommand}, 16'h0001);
        swClosed = 3'b110; tick(10); swClosed = 3'b100; waitBit(1, 1, 200);
        chk("3w reverse", {15'h0, reverseRunning}, 16'h0001);
        swClosed = 3'b000; waitBit(0, 0, 20);
        chk("3w stop", {15'h0, runCommand}, 16'h0000);
        // up/down terminals
        fn1 = FN_UP; fn2 = FN_DOWN; fn3 = 5'h00;
        frequencySourceSelect = FSRC_UPDN; tick(10); base = refF;
        swClosed = 3'b001; tick(40); swClosed = 3'b011; tick(8);
        chk("up", {15'h0, refF > base}, 16'h0001);
        base = refF; tick(20);
        chk("up+down", refF, base);
        swClosed = 3'b010; tick(400);
        chk("down sat", refF, 16'h0000);
        // floor becomes the target, then a slow stop at the set rate
        swClosed = 0; tick(10);
        fn1 = FN_FWD; fn2 = FN_REV; flr = 16'h0040; swClosed = 3'b001;
        tick(100);
        chk("active", {15'h0, motorActive}, 16'h0001);
        chk("out freq", outFrequency, 16'h0040);
        // 250.0 s from 50.00 Hz at 4 cycles a tenth: one step per 2 cycles
        dec = 14'h09C4; swClosed = 0; tick(10); base = outFrequency;
        tick(20);
        chk("decel rate", outFrequency, base - 16'h000A);
        tick(150);
        chk("stopped", outFrequency, 16'h0000);
        chk("idle", {15'h0, motorActive}, 16'h0000);
        stop_test();
    end
endmodule : dsr_speed_run_select_tb
